// ### src/adc_mode_config_port.sv
// Mode configuration port: serial register access or parallel static mode pins
//
// Operation
// - Mode select low: the four pins form a serial configuration port.
// - Mode select high: the four pins are static inputs for a reduced mode set.
// - Serial clock edges shift data only while chip select is low.
// - Serial input is sampled on each of the first 16 serial clock rising edges of a frame.
// - Readback bits change on falling edges so the host captures them on rising edges.
// - Serial output only pulls low or releases; an external pull-up makes high.
// - Parallel mode: chip select level enables the duty cycle stabilizer.
// - Parallel mode: serial clock level selects the output data format.
// - Parallel mode: data in and data out levels select the power-down state.
// - Each rising edge of the positive encode input sampled while clock enable is high starts a two-channel conversion.
`timescale 1ns/10ps
`default_nettype none
module adc_mode_config_port (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic clk_en,
  input wire logic prog_mode_select,
  input wire logic cs_n,
  input wire logic sck,
  input wire logic sdi,
  input wire logic sdo_in,
  output logic sdo_out,
  output logic sdo_oe_n,
  input wire logic encode_clock_pos,
  input wire logic encode_clock_neg,
  output var adc_cfg_pkg::mode_cfg_s mode_cfg,
  output logic conv_start,
  output logic encode_single_ended,
  output logic frame_busy
);

  // ****************************************
  // Pin synchronisation and edge finding
  // ****************************************
  adc_cfg_pkg::pin_in_s pins_raw;
  adc_cfg_pkg::pin_in_s pins;
  logic [1:0] edge_level;
  logic [1:0] edge_rise;
  logic [1:0] edge_fall;
  logic sck_rise;
  logic sck_fall;
  logic enc_rise;
  logic serial_mode;
  logic frame_active;
  assign pins_raw = {cs_n, sck, sdi, sdo_in, prog_mode_select, encode_clock_pos,
                     encode_clock_neg};
  pin_sync #(
    .W($bits(adc_cfg_pkg::pin_in_s)),
    .RST_VAL(adc_cfg_pkg::PINS_IDLE)
  ) u_pin_sync (
    .mclk(mclk),
    .arst_n(arst_n),
    .clk_en(clk_en),
    .d(pins_raw),
    .q(pins)
  );
  assign edge_level = {pins.encode_clock_pos, pins.sck};
  edge_find #(
    .W(2)
  ) u_edge_find (
    .mclk(mclk),
    .arst_n(arst_n),
    .clk_en(clk_en),
    .level(edge_level),
    .rise(edge_rise),
    .fall(edge_fall)
  );

  assign sck_rise = edge_rise[0];
  assign sck_fall = edge_fall[0];
  assign enc_rise = edge_rise[1];
  assign serial_mode = ~pins.prog_mode_select;
  assign frame_active = serial_mode & ~pins.cs_n;

  // ****************************************
  // Frame sequencing
  // ****************************************
  adc_cfg_pkg::xfer_state_e state_reg;
  logic [4:0] bit_cnt_reg;
  logic [7:0] shift_reg;
  logic [7:0] shift_next;
  logic [6:0] addr_reg;
  logic shift_en;
  assign shift_next = {shift_reg[6:0], pins.sdi};
  assign shift_en = frame_active & sck_rise & (state_reg != adc_cfg_pkg::XFER_DONE);
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= adc_cfg_pkg::XFER_IDLE;
    end else if (clk_en) begin
      if (!frame_active) begin
        state_reg <= adc_cfg_pkg::XFER_IDLE;
      end else if (sck_rise) begin
        case (state_reg)
          adc_cfg_pkg::XFER_IDLE: state_reg <= adc_cfg_pkg::XFER_HDR;
          adc_cfg_pkg::XFER_HDR: begin
            if (bit_cnt_reg == adc_cfg_pkg::HDR_LAST) begin
              state_reg <= shift_next[adc_cfg_pkg::RW_BIT] ? adc_cfg_pkg::XFER_READ
                                                            : adc_cfg_pkg::XFER_WRITE;
            end
          end
          adc_cfg_pkg::XFER_WRITE, adc_cfg_pkg::XFER_READ: begin
            if (bit_cnt_reg == adc_cfg_pkg::FRAME_LAST) begin
              state_reg <= adc_cfg_pkg::XFER_DONE;
            end
          end
          adc_cfg_pkg::XFER_DONE: state_reg <= adc_cfg_pkg::XFER_DONE;
          default: state_reg <= adc_cfg_pkg::XFER_IDLE;
        endcase
      end
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      bit_cnt_reg <= adc_cfg_pkg::CNT_ZERO;
    end else if (clk_en) begin
      if (!frame_active) begin
        bit_cnt_reg <= adc_cfg_pkg::CNT_ZERO;
      end else if (shift_en) begin
        bit_cnt_reg <= bit_cnt_reg + adc_cfg_pkg::CNT_ONE;
      end
    end
  end
  // Sample on serial clock rising edge
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      shift_reg <= 8'h00;
    end else if (clk_en) begin
      if (shift_en) begin
        shift_reg <= shift_next;
      end
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      addr_reg <= 7'h00;
    end else if (clk_en) begin
      if (shift_en && state_reg == adc_cfg_pkg::XFER_HDR
          && bit_cnt_reg == adc_cfg_pkg::HDR_LAST) begin
        addr_reg <= shift_next[6:0];
      end
    end
  end

  // ****************************************
  // Mode control registers
  // ****************************************
  logic [7:0] regs [adc_cfg_pkg::REG_COUNT];
  logic [31:0] regs_flat;
  logic wr_commit;
  logic addr_mapped;
  assign regs_flat = {regs[3], regs[2], regs[1], regs[0]};
  assign addr_mapped = (addr_reg <= adc_cfg_pkg::REG_FORMAT_IDX);
  assign wr_commit = shift_en && state_reg == adc_cfg_pkg::XFER_WRITE
                     && bit_cnt_reg == adc_cfg_pkg::FRAME_LAST;

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      regs[0] <= adc_cfg_pkg::REG_RESET_VAL;
      regs[1] <= adc_cfg_pkg::REG_POWER_VAL;
      regs[2] <= adc_cfg_pkg::REG_TIMING_VAL;
      regs[3] <= adc_cfg_pkg::REG_FORMAT_VAL;
    end else if (clk_en) begin
      if (wr_commit && addr_reg == adc_cfg_pkg::REG_RESET_IDX
          && shift_next[adc_cfg_pkg::RESET_BIT]) begin
        // Software reset bit clears itself with the rest of the map
        regs[0] <= adc_cfg_pkg::REG_RESET_VAL;
        regs[1] <= adc_cfg_pkg::REG_POWER_VAL;
        regs[2] <= adc_cfg_pkg::REG_TIMING_VAL;
        regs[3] <= adc_cfg_pkg::REG_FORMAT_VAL;
      end else if (wr_commit && addr_mapped) begin
        regs[addr_reg[1:0]] <= shift_next;
      end
    end
  end

  // ****************************************
  // Readback on open-drain output
  // ****************************************
  logic [7:0] rd_shift_reg;
  logic sdo_low_reg;
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      rd_shift_reg <= 8'h00;
    end else if (clk_en) begin
      if (shift_en && state_reg == adc_cfg_pkg::XFER_HDR
          && bit_cnt_reg == adc_cfg_pkg::HDR_LAST) begin
        rd_shift_reg <= (shift_next[6:0] <= adc_cfg_pkg::REG_FORMAT_IDX)
                        ? regs[shift_next[1:0]] : adc_cfg_pkg::READ_UNMAPPED;
      end else if (frame_active && sck_fall && state_reg == adc_cfg_pkg::XFER_READ) begin
        rd_shift_reg <= {rd_shift_reg[6:0], 1'b0};
      end
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      sdo_low_reg <= 1'b0;
    end else if (clk_en) begin
      if (!frame_active) begin
        sdo_low_reg <= 1'b0;
      end else if (sck_fall && state_reg == adc_cfg_pkg::XFER_READ) begin
        sdo_low_reg <= ~rd_shift_reg[7];
      end else if (sck_fall && state_reg == adc_cfg_pkg::XFER_DONE) begin
        sdo_low_reg <= 1'b0;
      end
    end
  end

  // Only ever pulls low; a one is a released line
  assign sdo_out = 1'b0;
  assign sdo_oe_n = ~sdo_low_reg;

  // ****************************************
  // Operating mode selection
  // ****************************************
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      mode_cfg <= adc_cfg_pkg::CFG_RESET;
    end else if (clk_en) begin
      if (pins.prog_mode_select) begin
        mode_cfg.stabilizer_en <= pins.cs_n;
        mode_cfg.out_format <= {1'b0, pins.sck};
        mode_cfg.power_down <= {pins.sdi, pins.sdo_in};
      end else begin
        mode_cfg.stabilizer_en <= regs[2][adc_cfg_pkg::STAB_BIT];
        mode_cfg.out_format <= regs[3][adc_cfg_pkg::FMT_LSB +: 2];
        mode_cfg.power_down <= regs[1][adc_cfg_pkg::PD_LSB +: 2];
      end
    end
  end

  // ****************************************
  // Encode and status
  // ****************************************
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      conv_start <= 1'b0;
    end else if (clk_en) begin
      conv_start <= enc_rise;
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      encode_single_ended <= 1'b0;
      frame_busy <= 1'b0;
    end else if (clk_en) begin
      encode_single_ended <= ~pins.encode_clock_neg;
      frame_busy <= frame_active;
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  property p_serial_cfg;
    @(posedge mclk) disable iff (!arst_n)
    clk_en && !pins.prog_mode_select |=> mode_cfg.power_down == $past(regs_flat[9:8]);
  endproperty
  a_serial_cfg: assert property (p_serial_cfg)
    else $error("serial mode power-down not taken from register");
  property p_par_no_write;
    @(posedge mclk) disable iff (!arst_n)
    clk_en && pins.prog_mode_select |=> $stable(regs_flat) && bit_cnt_reg == 5'h00;
  endproperty
  a_par_no_write: assert property (p_par_no_write)
    else $error("register changed in parallel mode");
  property p_cs_high_no_shift;
    @(posedge mclk) disable iff (!arst_n)
    clk_en && pins.cs_n && sck_rise |=> $stable(regs_flat) && $stable(shift_reg);
  endproperty
  a_cs_high_no_shift: assert property (p_cs_high_no_shift)
    else $error("shift while chip select high");
  property p_write_lands;
    @(posedge mclk) disable iff (!arst_n)
    clk_en && wr_commit && addr_reg == 7'h01 |=> regs_flat[15:8] == $past(shift_next);
  endproperty
  a_write_lands: assert property (p_write_lands)
    else $error("written byte not stored");
  property p_read_drive;
    @(posedge mclk) disable iff (!arst_n)
    clk_en && frame_active && sck_fall && state_reg == adc_cfg_pkg::XFER_READ
    |=> sdo_oe_n == $past(rd_shift_reg[7])
        ##1 (sdo_oe_n == $past(sdo_oe_n) || !$past(frame_active));
  endproperty
  a_read_drive: assert property (p_read_drive)
    else $error("readback bit wrong after falling edge");
  property p_open_drain;
    @(posedge mclk) disable iff (!arst_n)
    !sdo_oe_n |-> sdo_out == 1'b0 && (state_reg == adc_cfg_pkg::XFER_READ
                                      || state_reg == adc_cfg_pkg::XFER_DONE);
  endproperty
  a_open_drain: assert property (p_open_drain)
    else $error("serial output driven outside readback");
  property p_par_stab;
    @(posedge mclk) disable iff (!arst_n)
    clk_en && pins.prog_mode_select |=> mode_cfg.stabilizer_en == $past(pins.cs_n);
  endproperty
  a_par_stab: assert property (p_par_stab)
    else $error("stabilizer not following chip select");
  property p_par_fmt;
    @(posedge mclk) disable iff (!arst_n)
    clk_en && pins.prog_mode_select |=> mode_cfg.out_format == {1'b0, $past(pins.sck)};
  endproperty
  a_par_fmt: assert property (p_par_fmt)
    else $error("format not following serial clock pin");
  property p_par_pd;
    @(posedge mclk) disable iff (!arst_n)
    clk_en && pins.prog_mode_select
    |=> mode_cfg.power_down == {$past(pins.sdi), $past(pins.sdo_in)};
  endproperty
  a_par_pd: assert property (p_par_pd)
    else $error("power-down not following data pins");
  property p_conv;
    @(posedge mclk) disable iff (!arst_n)
    clk_en |=> conv_start == $past(enc_rise);
  endproperty
  a_conv: assert property (p_conv)
    else $error("conversion start not tied to encode edge");
  property p_abort;
    @(posedge mclk) disable iff (!arst_n)
    clk_en && !frame_active |=> bit_cnt_reg == 5'h00 && state_reg == adc_cfg_pkg::XFER_IDLE
                                && sdo_oe_n;
  endproperty
  a_abort: assert property (p_abort)
    else $error("frame not aborted by chip select");

endmodule
`default_nettype wire

// ### include/adc_cfg_pkg.sv
// Shared constants, carriers and state codes for the converter mode configuration port
package adc_cfg_pkg;

  // ****************************************
  // Serial frame layout
  // ****************************************
  localparam int FRAME_BITS = 16;
  localparam int HDR_BITS = 8;
  localparam int ADDR_BITS = 7;
  localparam int DATA_BITS = 8;
  localparam int CNT_BITS = 5;
  localparam logic [4:0] CNT_ZERO = 5'h00;
  localparam logic [4:0] CNT_ONE = 5'h01;
  localparam logic [4:0] HDR_LAST = 5'h07;
  localparam logic [4:0] FRAME_LAST = 5'h0f;
  localparam int RW_BIT = 7;

  // ****************************************
  // Mode control register map
  // ****************************************
  localparam int REG_COUNT = 4;
  localparam logic [6:0] REG_RESET_IDX = 7'h00;
  localparam logic [6:0] REG_POWER_IDX = 7'h01;
  localparam logic [6:0] REG_TIMING_IDX = 7'h02;
  localparam logic [6:0] REG_FORMAT_IDX = 7'h03;
  localparam int RESET_BIT = 7;
  localparam int PD_LSB = 0;
  localparam int STAB_BIT = 0;
  localparam int FMT_LSB = 0;
  localparam logic [7:0] REG_RESET_VAL = 8'h00;
  localparam logic [7:0] REG_POWER_VAL = 8'h00;
  localparam logic [7:0] REG_TIMING_VAL = 8'h00;
  localparam logic [7:0] REG_FORMAT_VAL = 8'h00;
  localparam logic [7:0] READ_UNMAPPED = 8'h00;

  // ****************************************
  // Carriers
  // ****************************************
  typedef struct packed {
    logic cs_n;
    logic sck;
    logic sdi;
    logic sdo_in;
    logic prog_mode_select;
    logic encode_clock_pos;
    logic encode_clock_neg;
  } pin_in_s;

  // Idle pin levels: chip select high, data out pulled up
  localparam pin_in_s PINS_IDLE = 7'h48;

  typedef struct packed {
    logic stabilizer_en;
    logic [1:0] out_format;
    logic [1:0] power_down;
  } mode_cfg_s;

  localparam mode_cfg_s CFG_RESET = 5'h00;

  typedef enum logic [2:0] {
    XFER_IDLE = 3'b000,
    XFER_HDR = 3'b001,
    XFER_WRITE = 3'b010,
    XFER_READ = 3'b011,
    XFER_DONE = 3'b100
  } xfer_state_e;

endpackage

// ### src/pin_sync.sv
// Two-flop synchroniser for a group of pin inputs
`timescale 1ns/10ps
`default_nettype none
module pin_sync #(
  parameter int W = 7,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic clk_en,
  input wire logic [W-1:0] d,
  output var logic [W-1:0] q
);

  logic [W-1:0] meta_reg;

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      meta_reg <= RST_VAL;
      q <= RST_VAL;
    end else if (clk_en) begin
      meta_reg <= d;
      q <= meta_reg;
    end
  end

endmodule
`default_nettype wire

// ### src/edge_find.sv
// Rising and falling edge finder for synchronised levels
`timescale 1ns/10ps
`default_nettype none
module edge_find #(
  parameter int W = 2
) (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic clk_en,
  input wire logic [W-1:0] level,
  output logic [W-1:0] rise,
  output logic [W-1:0] fall
);

  logic [W-1:0] prev_reg;

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      prev_reg <= '0;
    end else if (clk_en) begin
      prev_reg <= level;
    end
  end

  assign rise = level & ~prev_reg;
  assign fall = ~level & prev_reg;

endmodule
`default_nettype wire

// ### tb/host_ctrl_model.sv
// Behavioural host controller that drives the configuration pins
`timescale 1ns/10ps
`default_nettype none
module host_ctrl_model (
  input wire logic mclk,
  input wire logic sdo_out,
  input wire logic sdo_oe_n,
  output logic cs_n,
  output logic sck,
  output logic sdi,
  output logic sdo_level
);
  localparam int HALF = 8;
  logic drv_en;
  logic drv_val;

  // ****************************************
  // Open-drain data out line with pull-up
  // ****************************************
  assign sdo_level = (drv_en ? drv_val : 1'b1) & (sdo_oe_n ? 1'b1 : sdo_out);

  initial begin
    cs_n = 1'b1;
    sck = 1'b0;
    sdi = 1'b0;
    drv_en = 1'b0;
    drv_val = 1'b1;
  end

  // ****************************************
  // Serial frame, MSB first, optional early abort
  // ****************************************
  task automatic xfer(input logic [15:0] frame, input int nbits, input logic cs_lvl,
                      output logic [7:0] rd);
    int i;
    rd = 8'h00;
    @(posedge mclk);
    cs_n <= cs_lvl;
    sdi <= frame[15];
    repeat (HALF) @(posedge mclk);
    for (i = 0; i < nbits; i++) begin
      sck <= 1'b1;
      repeat (HALF) @(posedge mclk);
      if (i >= 8) rd = {rd[6:0], sdo_level};
      sck <= 1'b0;
      if (i < 15) sdi <= frame[14 - i];
      else sdi <= ~sdi;
      repeat (HALF) @(posedge mclk);
    end
    cs_n <= 1'b1;
    sdi <= ~sdi;
    repeat (HALF) @(posedge mclk);
  endtask

  // Static levels for parallel mode; p = {cs_n, sck, sdi, sdo}
  task automatic set_pins(input logic [3:0] p, input logic en);
    @(posedge mclk);
    cs_n <= p[3];
    sck <= p[2];
    sdi <= p[1];
    drv_val <= p[0];
    drv_en <= en;
  endtask
endmodule
`default_nettype wire

// ### tb/tb_top.sv
// Self-checking testbench for the mode configuration port
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  logic mclk;
  logic arst_n;
  logic clk_en;
  logic prog_mode_select;
  logic encode_clock_pos;
  logic encode_clock_neg;
  logic cs_n;
  logic sck;
  logic sdi;
  logic sdo_level;
  logic sdo_out;
  logic sdo_oe_n;
  logic conv_start;
  logic encode_single_ended;
  logic frame_busy;
  adc_cfg_pkg::mode_cfg_s mode_cfg;
  adc_cfg_pkg::mode_cfg_s exp_cfg;
  int fail_count;
  int cmp_count;
  int conv_count;
  int conv_base;
  logic [7:0] rd;

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  initial conv_count = 0;
  always @(posedge mclk) if (conv_start === 1'b1) conv_count <= conv_count + 1;

  adc_mode_config_port i_dut (
    .mclk(mclk), .arst_n(arst_n), .clk_en(clk_en), .prog_mode_select(prog_mode_select),
    .cs_n(cs_n), .sck(sck), .sdi(sdi), .sdo_in(sdo_level), .sdo_out(sdo_out),
    .sdo_oe_n(sdo_oe_n), .encode_clock_pos(encode_clock_pos),
    .encode_clock_neg(encode_clock_neg), .mode_cfg(mode_cfg), .conv_start(conv_start),
    .encode_single_ended(encode_single_ended), .frame_busy(frame_busy)
  );

  host_ctrl_model i_host (
    .mclk(mclk), .sdo_out(sdo_out), .sdo_oe_n(sdo_oe_n), .cs_n(cs_n), .sck(sck),
    .sdi(sdi), .sdo_level(sdo_level)
  );

  // ****************************************
  // Compare and access tasks
  // ****************************************
  task automatic chk_bit(input logic got, input logic exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %0t flag got %b exp %b", $time, got, exp);
    end
  endtask

  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %0t byte got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic chk_cfg(input adc_cfg_pkg::mode_cfg_s got, input adc_cfg_pkg::mode_cfg_s exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %0t config got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [6:0] addr, input logic [7:0] data);
    logic [7:0] dummy;
    i_host.xfer({1'b0, addr, data}, 16, 1'b0, dummy);
  endtask

  task automatic rdreg(input logic [6:0] addr, output logic [7:0] data);
    i_host.xfer({1'b1, addr, 8'h00}, 16, 1'b0, data);
  endtask

  task automatic end_of_test();
    $display("Counts: %0d compared, %0d mismatched", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  initial begin
    #500000;
    fail_count++;
    end_of_test();
  end

  // ****************************************
  // Test sequence
  // ****************************************
  initial begin
    arst_n = 1'b0;
    clk_en = 1'b1;
    prog_mode_select = 1'b0;
    encode_clock_pos = 1'b0;
    encode_clock_neg = 1'b0;
    fail_count = 0;
    cmp_count = 0;
    repeat (2) @(posedge mclk);
    arst_n <= 1'b1;
    repeat (4) @(posedge mclk);
    chk_cfg(mode_cfg, adc_cfg_pkg::CFG_RESET);
    chk_bit(sdo_oe_n, 1'b1);
    chk_bit(frame_busy, 1'b0);
    // Power, timing and format registers, then read back
    wr(adc_cfg_pkg::REG_POWER_IDX, 8'h03);
    wr(adc_cfg_pkg::REG_TIMING_IDX, 8'h01);
    wr(adc_cfg_pkg::REG_FORMAT_IDX, 8'h02);
    exp_cfg = 5'h1b;
    chk_cfg(mode_cfg, exp_cfg);
    rdreg(adc_cfg_pkg::REG_FORMAT_IDX, rd);
    chk_byte(rd, 8'h02);
    // Four extra clocks after the frame: line released, pull-up reads ones
    i_host.xfer({1'b1, adc_cfg_pkg::REG_FORMAT_IDX, 8'h00}, 20, 1'b0, rd);
    chk_byte(rd, 8'h2f);
    rdreg(adc_cfg_pkg::REG_POWER_IDX, rd);
    chk_byte(rd, 8'h03);
    rdreg(7'h05, rd);
    chk_byte(rd, adc_cfg_pkg::READ_UNMAPPED);
    wr(7'h04, 8'hff);
    chk_cfg(mode_cfg, exp_cfg);
    // Clocking with chip select high must not shift
    i_host.xfer({1'b0, adc_cfg_pkg::REG_POWER_IDX, 8'h00}, 16, 1'b1, rd);
    chk_cfg(mode_cfg, exp_cfg);
    // Partial frame, then a whole one
    i_host.xfer({1'b0, adc_cfg_pkg::REG_POWER_IDX, 8'h00}, 12, 1'b0, rd);
    fork
      wr(adc_cfg_pkg::REG_FORMAT_IDX, 8'h01);
      begin
        repeat (30) @(posedge mclk);
        chk_bit(frame_busy, 1'b1);
      end
    join
    exp_cfg = 5'h17;
    chk_cfg(mode_cfg, exp_cfg);
    rdreg(adc_cfg_pkg::REG_TIMING_IDX, rd);
    chk_byte(rd, 8'h01);
    // Self-clearing reset of all registers
    wr(adc_cfg_pkg::REG_RESET_IDX, 8'h80);
    chk_cfg(mode_cfg, adc_cfg_pkg::CFG_RESET);
    rdreg(adc_cfg_pkg::REG_RESET_IDX, rd);
    chk_byte(rd, 8'h00);
    // Parallel mode, every pin combination
    @(posedge mclk);
    prog_mode_select <= 1'b1;
    for (int k = 0; k < 16; k++) begin
      i_host.set_pins(k[3:0], 1'b1);
      repeat (6) @(posedge mclk);
      exp_cfg = {k[3], 1'b0, k[2], k[1], k[0]};
      chk_cfg(mode_cfg, exp_cfg);
      chk_bit(sdo_oe_n, 1'b1);
    end
    i_host.set_pins(4'h8, 1'b0);
    prog_mode_select <= 1'b0;
    // Frozen clock enable hides encode edges
    clk_en <= 1'b0;
    conv_base = conv_count;
    repeat (2) begin
      repeat (4) @(posedge mclk);
      encode_clock_pos <= ~encode_clock_pos;
    end
    repeat (4) @(posedge mclk);
    clk_en <= 1'b1;
    repeat (6) @(posedge mclk);
    chk_byte(8'(conv_count - conv_base), 8'h00);
    // Encode edges single-ended, then the differential flag only
    conv_base = conv_count;
    for (int j = 0; j < 20; j++) begin
      repeat (4) @(posedge mclk);
      encode_clock_pos <= ~encode_clock_pos;
    end
    repeat (6) @(posedge mclk);
    chk_byte(8'(conv_count - conv_base), 8'h0a);
    chk_bit(encode_single_ended, 1'b1);
    encode_clock_neg <= 1'b1;
    repeat (5) @(posedge mclk);
    chk_bit(encode_single_ended, 1'b0);
    end_of_test();
  end
endmodule
`default_nettype wire
